// ### inc/cltl_cfg.svh
// Register offsets, field positions, reset values and delay codes for the
// calibration trigger and low-power sequencing block.
// Assumes an 8-bit register port and a 10 MHz system clock.
`ifndef CLTL_CFG_SVH
`define CLTL_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CLTL_ADDR_PIN_OPT    8'h6B
`define CLTL_ADDR_SOFT_TRIG  8'h6C
`define CLTL_ADDR_LP_TIMING  8'h6E
`define CLTL_ADDR_GAIN_TRIM  8'h7A
`define CLTL_ADDR_CAL_FLAGS  8'h70
`define CLTL_ADDR_IRQ_STAT   8'h71
`define CLTL_ADDR_IRQ_MASK   8'h72

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CLTL_RST_PIN_OPT     8'h00
`define CLTL_RST_SOFT_TRIG   8'h01
`define CLTL_RST_LP_TIMING   8'h88
`define CLTL_RST_GAIN_TRIM   8'h00
`define CLTL_RST_IRQ_MASK    4'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CLTL_TRIG_SRC_BIT    0
`define CLTL_STAT_SEL_LSB    1
`define CLTL_STAT_SEL_MSB    2
`define CLTL_SW_TRIG_BIT     0
`define CLTL_LOW_POWER_CAL_ENABLE_BIT       0
`define CLTL_TRIGGER_PACED_SLEEP_BIT     1
`define CLTL_WAKE_LSB        3
`define CLTL_WAKE_MSB        4
`define CLTL_SLEEP_LSB       5
`define CLTL_SLEEP_MSB       7

// ----------------------------------------------------------------------------
// Writable masks; reserved interrupt-mask bits read back as zero
// ----------------------------------------------------------------------------
`define CLTL_IRQ_BITS        4

// ----------------------------------------------------------------------------
// Delay counts in system-clock periods
// ----------------------------------------------------------------------------
`define CLTL_DLY_0           41'h000_0000_0480
`define CLTL_DLY_1           41'h000_0040_0080
`define CLTL_DLY_2           41'h000_0200_0080
`define CLTL_DLY_3           41'h000_1000_0080
`define CLTL_DLY_4           41'h000_8000_0080
`define CLTL_DLY_5           41'h004_0000_0080
`define CLTL_DLY_6           41'h020_0000_0080
`define CLTL_DLY_7           41'h100_0000_0080
`define CLTL_CNT_W           41

`endif

// ### inc/cltl_pkg.sv
// Types shared by the calibration trigger and low-power block.
// Assumes nothing of its surroundings.
package cltl_pkg;
    typedef enum logic [4:0] {
        CLTL_IDLE   = 5'b00001,
        CLTL_ACTIVE = 5'b00010,
        CLTL_SLEEP  = 5'b00100,
        CLTL_SETTLE = 5'b01000,
        CLTL_CAL    = 5'b10000
    } cltl_lp_state_t;
endpackage

// ### inc/cltl_sync_if.sv
// Interface that carries the raw trigger pin to the synchroniser and the
// filtered level back.
// Assumes a single clock domain on the consumer side.
`timescale 1ns/1ps
interface cltl_sync_if;
    logic raw_level;
    logic clean_level;
    modport sync (input raw_level, output clean_level);
    modport user (output raw_level, input clean_level);
endinterface

// ### core/cltl_sync.sv
// Three-stage synchroniser for a pin level; a change is accepted once the
// second and third stages agree.
// Assumes an asynchronous active-low reset.
`timescale 1ns/1ps
module cltl_sync (
    input  wire logic  clk,
    input  wire logic  rst_n,
    cltl_sync_if.sync  port
);
    logic [2:0] stage;
    logic       level;

    // ------------------------------------------------------------------------
    // Capture chain and agreement filter
    // ------------------------------------------------------------------------
    // Stage 0 only feeds stage 1; the filter looks at stages 1 and 2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], port.raw_level};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level <= stage[2];
        end
    end

    assign port.clean_level = level;
endmodule

// ### core/cltl_delay.sv
// Down-counter that reports done when the loaded period has elapsed.
// Assumes load and period come from the same clock domain.
`timescale 1ns/1ps
`include "cltl_cfg.svh"
module cltl_delay (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   load,
    input  wire logic [`CLTL_CNT_W-1:0] period,
    output logic                        done
);
    logic [`CLTL_CNT_W-1:0] remain;

    // ------------------------------------------------------------------------
    // Count down to zero; done flags for the one cycle at a count of one
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= period;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done = (remain == {{(`CLTL_CNT_W-1){1'b0}}, 1'b1});
endmodule

// ### core/cltl_top.sv
// Calibration trigger source select, status pin select and low-power
// background calibration sequencing, with an 8-bit register port.
// Assumes one 10 MHz clock; the hardware trigger pin is asynchronous.
//
// Functional notes
// - Status select 0/1/2 shows foreground done, cal stopped, alarm.
// - Status select 3 holds the status pin low.
// - Trigger source 0 uses the software bit, ignores the pin.
// - Trigger source 1 uses the pin, ignores the software bit.
// - Software trigger bit resets to 1 and stands in for the pin.
// - Sleep code sets sleep period, autonomous mode only.
// - Wake code sets settling time before calibration starts.
// - Trigger-paced bit 0: sleep timed by the sleep code.
// - Trigger-paced bit 1: sleep while trigger high, wake when low.
// - Low-power enable resets to 0, acts only with background cal on.
// - Foreground done flag high once foreground cal done or skipped.
// - Cal stopped flag tracks background stop, or foreground done.
`timescale 1ns/1ps
`include "cltl_cfg.svh"
module cltl_top (
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR_STB,
    input  wire logic       RD_STB,
    output logic      [7:0] RDATA,
    input  wire logic       HW_TRIGGER_INPUT,
    input  wire logic       BACKGROUND_CAL_ENABLE,
    input  wire logic       FG_CAL_DONE,
    input  wire logic       BG_CAL_STOPPED,
    input  wire logic       CAL_ALARM,
    input  wire logic       CORE_CAL_DONE,
    output logic            CAL_STATE_OUTPUT_PIN,
    output logic            CAL_TRIGGER,
    output logic            CORE_SLEEP,
    output logic            CORE_CAL_START,
    output logic            IRQ
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]                  pin_opt;
    logic [7:0]                  soft_trig;
    logic [7:0]                  lp_timing;
    logic [7:0]                  gain_trim;
    logic [`CLTL_IRQ_BITS-1:0]   irq_stat;
    logic [`CLTL_IRQ_BITS-1:0]   irq_mask;
    logic [`CLTL_IRQ_BITS-1:0]   irq_event;
    logic                        wr_pin;
    logic                        wr_soft;
    logic                        wr_lp;
    logic                        wr_gain;
    logic                        wr_mask;
    logic                        rd_stat;
    logic                        trig_src;
    logic [1:0]                  stat_sel;
    logic                        low_power_cal_enable;
    logic                        lp_paced;
    logic [1:0]                  wake_code;
    logic [2:0]                  sleep_code;
    logic                        hw_trig_sync;
    logic                        trig_level;
    logic                        lp_active;
    logic                        foreground_complete_flag_flag;
    logic                        stopped_flag;
    logic                        alarm_flag;
    logic                        sleep_done;
    logic                        settle_done;
    logic                        sleep_load;
    logic                        settle_load;
    logic [`CLTL_CNT_W-1:0]      sleep_period;
    logic [`CLTL_CNT_W-1:0]      settle_period;
    cltl_pkg::cltl_lp_state_t    lp_state;
    cltl_pkg::cltl_lp_state_t    next_lp_state;
    logic                        stopped_q;
    logic                        cal_start_q;

    cltl_sync_if trig_if ();

    assign wr_pin  = WR_STB && (ADDR == `CLTL_ADDR_PIN_OPT);
    assign wr_soft = WR_STB && (ADDR == `CLTL_ADDR_SOFT_TRIG);
    assign wr_lp   = WR_STB && (ADDR == `CLTL_ADDR_LP_TIMING);
    assign wr_gain = WR_STB && (ADDR == `CLTL_ADDR_GAIN_TRIM);
    assign wr_mask = WR_STB && (ADDR == `CLTL_ADDR_IRQ_MASK);
    assign rd_stat = RD_STB && (ADDR == `CLTL_ADDR_IRQ_STAT);

    // Field extraction
    assign trig_src   = pin_opt[`CLTL_TRIG_SRC_BIT];
    assign stat_sel   = pin_opt[`CLTL_STAT_SEL_MSB:`CLTL_STAT_SEL_LSB];
    assign low_power_cal_enable      = lp_timing[`CLTL_LOW_POWER_CAL_ENABLE_BIT];
    assign lp_paced   = lp_timing[`CLTL_TRIGGER_PACED_SLEEP_BIT];
    assign wake_code  = lp_timing[`CLTL_WAKE_MSB:`CLTL_WAKE_LSB];
    assign sleep_code = lp_timing[`CLTL_SLEEP_MSB:`CLTL_SLEEP_LSB];

    // ------------------------------------------------------------------------
    // Register writes; reserved bits stored as written, except in the interrupt mask
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_opt   <= `CLTL_RST_PIN_OPT;
            soft_trig <= `CLTL_RST_SOFT_TRIG;
            lp_timing <= `CLTL_RST_LP_TIMING;
            gain_trim <= `CLTL_RST_GAIN_TRIM;
            irq_mask  <= `CLTL_RST_IRQ_MASK;
        end else begin
            if (wr_pin)  pin_opt   <= WDATA;
            if (wr_soft) soft_trig <= WDATA;
            if (wr_lp)   lp_timing <= WDATA;
            if (wr_gain) gain_trim <= WDATA;
            if (wr_mask) irq_mask  <= WDATA[`CLTL_IRQ_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read port, data valid in the cycle after the strobe
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 8'h00;
        end else if (RD_STB) begin
            case (ADDR)
                `CLTL_ADDR_PIN_OPT:   RDATA <= pin_opt;
                `CLTL_ADDR_SOFT_TRIG: RDATA <= soft_trig;
                `CLTL_ADDR_LP_TIMING: RDATA <= lp_timing;
                `CLTL_ADDR_GAIN_TRIM: RDATA <= gain_trim;
                `CLTL_ADDR_CAL_FLAGS: RDATA <= {3'h0, lp_active, trig_level,
                                                alarm_flag, stopped_flag,
                                                foreground_complete_flag_flag};
                `CLTL_ADDR_IRQ_STAT:  RDATA <= {4'h0, irq_stat};
                `CLTL_ADDR_IRQ_MASK:  RDATA <= {4'h0, irq_mask};
                default:              RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Trigger source: synchronised pin or software bit
    // ------------------------------------------------------------------------
    assign trig_if.raw_level = HW_TRIGGER_INPUT;

    cltl_sync u_trig_sync (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .port  (trig_if.sync)
    );

    assign hw_trig_sync = trig_if.clean_level;
    // Source 1 takes the pin, source 0 the software bit
    assign trig_level = trig_src ? hw_trig_sync
                                 : soft_trig[`CLTL_SW_TRIG_BIT];

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CAL_TRIGGER <= 1'b1;
        end else begin
            CAL_TRIGGER <= trig_level;
        end
    end

    // ------------------------------------------------------------------------
    // Calibration flags from the calibration engine
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            foreground_complete_flag_flag <= 1'b0;
            stopped_flag <= 1'b0;
            alarm_flag   <= 1'b0;
        end else begin
            foreground_complete_flag_flag <= FG_CAL_DONE;
            // Without background cal, stopped follows foreground done
            stopped_flag <= BACKGROUND_CAL_ENABLE ? BG_CAL_STOPPED
                                                  : FG_CAL_DONE;
            alarm_flag   <= CAL_ALARM;
        end
    end

    // ------------------------------------------------------------------------
    // Status pin selection
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CAL_STATE_OUTPUT_PIN <= 1'b0;
        end else begin
            case (stat_sel)
                2'h0:    CAL_STATE_OUTPUT_PIN <= foreground_complete_flag_flag;
                2'h1:    CAL_STATE_OUTPUT_PIN <= stopped_flag;
                2'h2:    CAL_STATE_OUTPUT_PIN <= alarm_flag;
                default: CAL_STATE_OUTPUT_PIN <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Low-power sequencer: sleep, settle, then calibrate the offline core
    // ------------------------------------------------------------------------
    assign lp_active = low_power_cal_enable && BACKGROUND_CAL_ENABLE;

    // Sleep period lookup by code
    always_comb begin
        case (sleep_code)
            3'h0:    sleep_period = `CLTL_DLY_0;
            3'h1:    sleep_period = `CLTL_DLY_1;
            3'h2:    sleep_period = `CLTL_DLY_2;
            3'h3:    sleep_period = `CLTL_DLY_3;
            3'h4:    sleep_period = `CLTL_DLY_4;
            3'h5:    sleep_period = `CLTL_DLY_5;
            3'h6:    sleep_period = `CLTL_DLY_6;
            default: sleep_period = `CLTL_DLY_7;
        endcase
    end

    // Settle period lookup by code
    always_comb begin
        case (wake_code)
            2'h0:    settle_period = `CLTL_DLY_0;
            2'h1:    settle_period = `CLTL_DLY_2;
            2'h2:    settle_period = `CLTL_DLY_3;
            default: settle_period = `CLTL_DLY_4;
        endcase
    end

    // Next-state logic
    always_comb begin
        next_lp_state = lp_state;
        sleep_load    = 1'b0;
        settle_load   = 1'b0;
        case (lp_state)
            cltl_pkg::CLTL_IDLE: begin
                if (lp_active) begin
                    next_lp_state = cltl_pkg::CLTL_SLEEP;
                    sleep_load    = 1'b1;
                end
            end
            cltl_pkg::CLTL_SLEEP: begin
                if (!lp_active) begin
                    next_lp_state = cltl_pkg::CLTL_IDLE;
                end else if (lp_paced ? !trig_level
                                      : sleep_done) begin
                    next_lp_state = cltl_pkg::CLTL_SETTLE;
                    settle_load   = 1'b1;
                end
            end
            cltl_pkg::CLTL_SETTLE: begin
                if (!lp_active) begin
                    next_lp_state = cltl_pkg::CLTL_IDLE;
                end else if (settle_done) begin
                    next_lp_state = cltl_pkg::CLTL_CAL;
                end
            end
            cltl_pkg::CLTL_CAL: begin
                if (!lp_active) begin
                    next_lp_state = cltl_pkg::CLTL_IDLE;
                end else if (CORE_CAL_DONE) begin
                    next_lp_state = cltl_pkg::CLTL_SLEEP;
                    sleep_load    = 1'b1;
                end
            end
            default: begin
                next_lp_state = cltl_pkg::CLTL_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lp_state <= cltl_pkg::CLTL_IDLE;
        end else begin
            lp_state <= next_lp_state;
        end
    end

    cltl_delay u_sleep_dly (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .load   (sleep_load),
        .period (sleep_period),
        .done   (sleep_done)
    );

    cltl_delay u_settle_dly (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .load   (settle_load),
        .period (settle_period),
        .done   (settle_done)
    );

    // Core control outputs
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CORE_SLEEP  <= 1'b0;
            cal_start_q <= 1'b0;
        end else begin
            CORE_SLEEP  <= (next_lp_state == cltl_pkg::CLTL_SLEEP);
            cal_start_q <= (lp_state == cltl_pkg::CLTL_SETTLE) &&
                           (next_lp_state == cltl_pkg::CLTL_CAL);
        end
    end
    assign CORE_CAL_START = cal_start_q;

    // ------------------------------------------------------------------------
    // Interrupts: foreground_complete_flag, stop, alarm, wake; set wins over read-clear
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= stopped_flag;
        end
    end

    assign irq_event = {settle_load, CAL_ALARM && !alarm_flag,
                        stopped_flag && !stopped_q,
                        FG_CAL_DONE && !foreground_complete_flag_flag};

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (rd_stat ? 4'h0 : irq_stat) | irq_event;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((rd_stat ? 4'h0 : irq_stat) | irq_event) & irq_mask);
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    stat_low_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (stat_sel == 2'h3) |=> !CAL_STATE_OUTPUT_PIN)
        else $error("status pin not low with select 3");

    stat_fg_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (stat_sel == 2'h0) |=> CAL_STATE_OUTPUT_PIN == $past(foreground_complete_flag_flag))
        else $error("status pin does not follow foreground_complete_flag");

    sw_src_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !trig_src |=> CAL_TRIGGER == $past(soft_trig[0]))
        else $error("software trigger not used");

    hw_src_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        trig_src |=> CAL_TRIGGER == $past(hw_trig_sync))
        else $error("hardware trigger not used");

    paced_wake_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (lp_state == cltl_pkg::CLTL_SLEEP && lp_active && lp_paced &&
         trig_level) |=> lp_state == cltl_pkg::CLTL_SLEEP)
        else $error("core woke while trigger high");

    lp_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !lp_active [*2] |-> !CORE_SLEEP)
        else $error("core asleep with low power off");

    stop_fg_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !BACKGROUND_CAL_ENABLE |=> stopped_flag == $past(FG_CAL_DONE))
        else $error("stopped flag not following foreground_complete_flag");

    fg_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        FG_CAL_DONE |=> foreground_complete_flag_flag)
        else $error("foreground_complete_flag flag missing");
endmodule

// ### tb/cltl_trig_host.sv
// Host-side model that drives the hardware trigger pin.
// Assumes the bench calls set_level between rising clock edges.
`timescale 1ns/1ps
module cltl_trig_host (
    input  wire logic clk,
    output logic      trig_pin
);
    // ----
    // Pin level, idle high
    // ----
    initial trig_pin = 1'b1;

    // New level launched just after a rising edge
    task automatic set_level(input logic lvl);
        @(posedge clk);
        trig_pin <= lvl;
    endtask
endmodule

// ### tb/test_cltl_top.sv
// Self-checking bench for the calibration trigger and low-power block.
// Assumes the design files and cltl_trig_host are compiled first.
`timescale 1ns/1ps
module test_cltl_top;
    logic       sys_clk = 1'b0;
    logic       resetn  = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic       wr_stb  = 1'b0;
    logic       rd_stb  = 1'b0;
    logic       bg_en   = 1'b0;
    logic [2:0] flags   = 3'h0;  // Alarm, stopped, foreground done
    logic       cdone   = 1'b0;
    logic [7:0] rdata;
    logic       hw_trig, stat_pin, cal_trig, sleep, start, irq;
    logic [2:0] ev;
    int         errors = 0;
    int         n_compared = 0;
    int         n;

    // ----
    // Clock, design, host model
    // ----
    always #50 sys_clk = ~sys_clk;
    assign ev = {sleep, !sleep, start};
    cltl_top i_cltl_top (
        .SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .HW_TRIGGER_INPUT(hw_trig), .BACKGROUND_CAL_ENABLE(bg_en),
        .FG_CAL_DONE(flags[0]), .BG_CAL_STOPPED(flags[1]),
        .CAL_ALARM(flags[2]), .CORE_CAL_DONE(cdone),
        .CAL_STATE_OUTPUT_PIN(stat_pin), .CAL_TRIGGER(cal_trig),
        .CORE_SLEEP(sleep), .CORE_CAL_START(start), .IRQ(irq));
    cltl_trig_host i_cltl_trig_host (.clk(sys_clk), .trig_pin(hw_trig));

    // ----
    // Shared tasks
    // ----
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        check(rdata, exp);
    endtask
    // Wait some edges, then look between edges
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wait_ev(input int sel);
        n = 0;
        while (n < 3000 && ev[sel] !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        check({7'h0, cal_trig}, 8'h01);
        rd(8'h6C, 8'h01);
        rd(8'h6E, 8'h88);
        rd(8'h6B, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h7A, 8'hA5);
        rd(8'h7A, 8'hA5);
    endtask
    task automatic t_source();
        i_cltl_trig_host.set_level(1'b0);
        settle(8); check({7'h0, cal_trig}, 8'h01);
        wr(8'h6C, 8'h00);
        settle(3); check({7'h0, cal_trig}, 8'h00);
        wr(8'h6B, 8'h01);
        i_cltl_trig_host.set_level(1'b1);
        settle(1); check({7'h0, cal_trig}, 8'h00);
        settle(5); check({7'h0, cal_trig}, 8'h01);
        i_cltl_trig_host.set_level(1'b0);
        wr(8'h6C, 8'h01);
        settle(6); check({7'h0, cal_trig}, 8'h00);
        wr(8'h6B, 8'h00);
    endtask
    task automatic t_status();
        // Background on so the stopped flag follows its own input
        bg_en <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'h6B, 8'(s << 1));
            flags <= 3'h0;
            settle(3); check({7'h0, stat_pin}, 8'h00);
            @(posedge sys_clk);
            flags <= (s < 3) ? 3'(1 << s) : 3'h7;
            settle(3); check({7'h0, stat_pin}, {7'h0, s < 3});
        end
        check({7'h0, irq}, 8'h00);
        wr(8'h72, 8'h01);
        settle(2); check({7'h0, irq}, 8'h01);
        rd(8'h71, 8'h07);
        settle(2); check({7'h0, irq}, 8'h00);
        @(posedge sys_clk);
        flags <= 3'h0;
        bg_en <= 1'b0;
    endtask
    task automatic t_lowpower();
        wr(8'h6E, 8'h83);
        settle(20); check({7'h0, sleep}, 8'h00);
        @(posedge sys_clk);
        bg_en <= 1'b1;
        wait_ev(2); check({7'h0, n < 12}, 8'h01);
        settle(60); check({7'h0, sleep}, 8'h01);
        wr(8'h6C, 8'h00);
        wait_ev(1); check({7'h0, n < 12}, 8'h01);
        wait_ev(0); check({7'h0, n > 1100 && n < 1170}, 8'h01);
        wr(8'h6C, 8'h01);
        cdone <= 1'b1;
        @(posedge sys_clk);
        cdone <= 1'b0;
        wait_ev(2); check({7'h0, n < 12}, 8'h01);
        @(posedge sys_clk);
        bg_en <= 1'b0;
        wr(8'h6E, 8'h01);
        settle(5);
        @(posedge sys_clk);
        bg_en <= 1'b1;
        wait_ev(2);
        wait_ev(1); check({7'h0, n > 1100 && n < 1170}, 8'h01);
        wait_ev(0); check({7'h0, n > 1100 && n < 1170}, 8'h01);
        // Wake code 1: settling far longer than the watch window
        wr(8'h6E, 8'h8B);
        cdone <= 1'b1;
        @(posedge sys_clk);
        cdone <= 1'b0;
        wr(8'h6C, 8'h00);
        wait_ev(0); check({7'h0, n < 3000}, 8'h00);
    endtask

    // Reset, then all scenarios in turn
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_source();
        t_status();
        t_lowpower();
        close_out();
    end
    // Watchdog well beyond the expected run time
    initial begin
        #3_000_000;
        errors++;
        close_out();
    end
endmodule
